// ### hdl/ics_regs.vh
// register offsets, field positions and reset values of the interrupt combine block
`ifndef ICS_REGS_VH
`define ICS_REGS_VH
`define ICS_IDX_INT_CTL      8'h11
`define ICS_IDX_SLEW_STAT    8'h12
`define ICS_IDX_PIN_CTL      8'h13
`define ICS_IDX_INT_FLAG     8'h14
`define ICS_IDX_INT_MASK     8'h15
`define ICS_IDX_INT_POL      8'h16
`define ICS_IDX_IRQ_LIVE_STATE     8'h17
`define ICS_IDX_PIN_SEL      8'h18
`define ICS_BIT_INT_EN       0
`define ICS_BIT_AND_OR       1
`define ICS_BIT_PIN0_OD      0
`define ICS_BIT_PIN1_OD      1
`define ICS_BIT_PIN0_SPIKE   4
`define ICS_BIT_PIN1_SPIKE   5
`define ICS_INT_CTL_RST      2'h0
`define ICS_PIN_CTL_RST      8'h00
`define ICS_FLAG_RST         8'h00
`define ICS_MASK_RST         8'h00
`define ICS_POL_RST          8'h00
`define ICS_PIN_SEL_RST      1'h0
`define ICS_PIN_CTL_WMASK    8'h3f
`define ICS_NSRC             8
`endif

// ### hdl/ics_flag_bit.v
// one latched interrupt flag with edge detect, polarity and write-zero clear
`default_nettype none
module ics_flag_bit (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  input  wire clk_en,
  // control
  input  wire src,
  input  wire src_prev,
  input  wire edge_pol,
  input  wire int_en,
  input  wire clr,
  // state
  output reg  flag_ff
);

  wire edge_hit;
  wire nxt_flag;

  assign edge_hit = edge_pol ? (src & ~src_prev) : (~src & src_prev); // RULE_12
  // set wins over clear; frozen while disabled
  assign nxt_flag = ~int_en ? flag_ff : // RULE_06
                    (edge_hit ? 1'b1 : (clr ? 1'b0 : flag_ff)); // RULE_13

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= 1'b0;
    end else if (clk_en) begin
      flag_ff <= nxt_flag;
    end
  end

endmodule // ics_flag_bit
`default_nettype wire

// ### hdl/ics_top.v
// interrupt combine, status pin control and slew status registers over apb
//
// The APB interface to the registers was left to the implementer.
`include "ics_regs.vh"
`default_nettype none
// What this block does
// RULE_01: with combine-select 1, interrupt only when all unmasked flags are set.
// RULE_02: with combine-select 0, interrupt when any unmasked flag is set.
// RULE_03: combine-select and enable are read-write, reset 0, loadable from startup image.
// RULE_04: interrupt circuit works only while enable bit 0 is 1.
// RULE_05: with enable 0, no interrupt appears on the status pins.
// RULE_06: with enable 0, latched flags never change.
// RULE_07: live register always shows raw source state regardless of enable.
// RULE_08: four read-only slew valid bits at 7..4, reset to 0.
// RULE_09: open-drain enable bits 1 and 0 for status pins, reset 0.
// RULE_10: spike limit bits 5 and 4 per status pin, reset 0, driven out.
// RULE_11: a masked source never contributes to the interrupt.
// RULE_12: flag set on rising edge if polarity 1, falling edge if 0.
// RULE_13: software clears a flag by writing 0; flags reset to 0.
// RULE_14: interrupt registered from flags and masks, one stage, to selected pin.
module ics_top #(
  parameter NSRC = `ICS_NSRC
) (
  // apb clock and reset
  input  wire             pclk,
  input  wire             presetn,
  input  wire             clk_en,
  // apb slave
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  input  wire [3:0]       pstrb,
  output reg  [31:0]      prdata,
  output reg              pready,
  output reg              pslverr,
  // startup configuration load
  input  wire             cfg_load,
  input  wire [1:0]       cfg_int_ctl,
  // interrupt sources and slew detector
  input  wire [NSRC-1:0]  irq_src,
  input  wire [3:0]       slew_valid,
  // status pins
  output reg              status_out_a,
  output reg              status_out_a_oe,
  output reg              status_out_b,
  output reg              status_out_b_oe,
  output reg              pin0_open_drain_en,
  output reg              pin1_open_drain_en,
  output reg              pin0_spike_limit,
  output reg              pin1_spike_limit
);

  // ************************************************
  // registers
  // ************************************************
  reg  [1:0]      int_ctl_ff;
  reg  [7:0]      pin_ctl_ff;
  reg  [NSRC-1:0] mask_ff;
  reg  [NSRC-1:0] pol_ff;
  reg  [NSRC-1:0] irq_live_state_ff;
  reg  [3:0]      slew_ff;
  reg             pin_sel_ff;
  wire [NSRC-1:0] flag_ff;
  wire [NSRC-1:0] flag_clr;

  wire [9:0]      widx;
  wire            acc;
  wire            commit;
  wire            wr;
  wire            wr_lo;
  wire            hit;
  wire            ro_hit;
  wire            nxt_err;

  wire            int_en;
  wire            and_or;
  wire [NSRC-1:0] act;
  wire            comb;
  wire            nxt_irq;

  wire            we_int_ctl;
  wire            we_pin_ctl;
  wire            we_flag;
  wire            we_mask;
  wire            we_pol;
  wire            we_pin_sel;

  wire [31:0]     rd_int_ctl;
  wire [31:0]     rd_slew;
  wire [31:0]     rd_pin_ctl;
  wire [31:0]     rd_flag;
  wire [31:0]     rd_mask;
  wire [31:0]     rd_pol;
  wire [31:0]     rd_live;
  wire [31:0]     rd_pin_sel;
  reg  [31:0]     nxt_rdata;

  reg             nxt_stat_a;
  reg             nxt_stat_b;
  reg             nxt_oe_a;
  reg             nxt_oe_b;

  reg  [1:0]      state_ff;
  reg  [1:0]      nxt_state;

  assign widx   = paddr[11:2];
  assign int_en = int_ctl_ff[`ICS_BIT_INT_EN];
  assign and_or = int_ctl_ff[`ICS_BIT_AND_OR];

  // ************************************************
  // apb handshake
  // ************************************************
  localparam [1:0] ST_WAIT  = 2'b01;
  localparam [1:0] ST_DONE  = 2'b10;
  localparam       NSRC_PAD = 32 - NSRC;

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_WAIT: begin
        if (psel && penable) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_state = ST_WAIT;
      end
      default: begin
        nxt_state = ST_WAIT;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_WAIT;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // access taken in wait state, write committed at the ready edge
  assign acc    = psel & penable & state_ff[0];
  assign commit = psel & penable & state_ff[1];
  assign wr     = commit & pwrite;
  assign wr_lo  = wr & pstrb[0];

  // ************************************************
  // write decode and errors
  // ************************************************
  assign we_int_ctl = wr_lo & (widx == {2'h0, `ICS_IDX_INT_CTL});
  assign we_pin_ctl = wr_lo & (widx == {2'h0, `ICS_IDX_PIN_CTL});
  assign we_flag    = wr_lo & (widx == {2'h0, `ICS_IDX_INT_FLAG});
  assign we_mask    = wr_lo & (widx == {2'h0, `ICS_IDX_INT_MASK});
  assign we_pol     = wr_lo & (widx == {2'h0, `ICS_IDX_INT_POL});
  assign we_pin_sel = wr_lo & (widx == {2'h0, `ICS_IDX_PIN_SEL});
  assign ro_hit     = (widx == {2'h0, `ICS_IDX_SLEW_STAT}) | (widx == {2'h0, `ICS_IDX_IRQ_LIVE_STATE});
  assign nxt_err    = acc & (~hit | (pwrite & ro_hit));

  // ************************************************
  // flags
  // ************************************************
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_flag
      assign flag_clr[g] = we_flag & ~pwdata[g]; // RULE_13
      ics_flag_bit u_flag (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_en   (clk_en),
        .src      (irq_src[g]),
        .src_prev (irq_live_state_ff[g]),
        .edge_pol (pol_ff[g]),
        .int_en   (int_en),
        .clr      (flag_clr[g]),
        .flag_ff  (flag_ff[g])
      );
    end
  endgenerate

  // ************************************************
  // combine
  // ************************************************
  assign act     = flag_ff | mask_ff; // RULE_11
  assign comb    = and_or ? ((&act) & ~(&mask_ff)) // RULE_01
                          : (|(flag_ff & ~mask_ff)); // RULE_02
  assign nxt_irq = int_en & comb; // RULE_04

  // ************************************************
  // source sampling
  // ************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_live_state_ff <= {NSRC{1'b0}};
      slew_ff           <= 4'h0;
    end else if (clk_en) begin
      irq_live_state_ff <= irq_src; // RULE_07
      slew_ff           <= slew_valid; // RULE_08
    end
  end

  // ************************************************
  // status pins
  // ************************************************
  always @* begin
    nxt_stat_a = 1'b0;
    nxt_stat_b = 1'b0;
    nxt_oe_a   = 1'b1;
    nxt_oe_b   = 1'b1;
    if (pin_sel_ff) begin
      nxt_stat_b = nxt_irq; // RULE_05
    end else begin
      nxt_stat_a = nxt_irq; // RULE_05
    end
    // open drain: drive low only, release for high
    if (pin_ctl_ff[`ICS_BIT_PIN0_OD]) begin
      nxt_oe_a = ~nxt_stat_a; // RULE_09
    end
    if (pin_ctl_ff[`ICS_BIT_PIN1_OD]) begin
      nxt_oe_b = ~nxt_stat_b; // RULE_09
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_out_a    <= 1'b0;
      status_out_a_oe <= 1'b1;
      status_out_b    <= 1'b0;
      status_out_b_oe <= 1'b1;
    end else if (clk_en) begin
      status_out_a    <= nxt_stat_a; // RULE_14
      status_out_a_oe <= nxt_oe_a;
      status_out_b    <= nxt_stat_b; // RULE_14
      status_out_b_oe <= nxt_oe_b;
    end
  end

  // ************************************************
  // config registers
  // ************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_ctl_ff <= `ICS_INT_CTL_RST; // RULE_03
    end else if (clk_en) begin
      if (cfg_load) begin
        int_ctl_ff <= cfg_int_ctl; // RULE_03
      end else if (we_int_ctl) begin
        int_ctl_ff <= pwdata[1:0]; // RULE_03
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ctl_ff <= `ICS_PIN_CTL_RST;
    end else if (clk_en && we_pin_ctl) begin
      pin_ctl_ff <= pwdata[7:0] & `ICS_PIN_CTL_WMASK; // RULE_10
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= {NSRC{1'b0}};
    end else if (clk_en && we_mask) begin
      mask_ff <= pwdata[NSRC-1:0]; // RULE_11
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_ff <= {NSRC{1'b0}};
    end else if (clk_en && we_pol) begin
      pol_ff <= pwdata[NSRC-1:0]; // RULE_12
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sel_ff <= `ICS_PIN_SEL_RST;
    end else if (clk_en && we_pin_sel) begin
      pin_sel_ff <= pwdata[0];
    end
  end

  // ************************************************
  // pin driver controls
  // ************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin0_open_drain_en <= 1'b0;
      pin0_spike_limit   <= 1'b0;
    end else if (clk_en) begin
      pin0_open_drain_en <= pin_ctl_ff[`ICS_BIT_PIN0_OD]; // RULE_09
      pin0_spike_limit   <= pin_ctl_ff[`ICS_BIT_PIN0_SPIKE]; // RULE_10
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin1_open_drain_en <= 1'b0;
      pin1_spike_limit   <= 1'b0;
    end else if (clk_en) begin
      pin1_open_drain_en <= pin_ctl_ff[`ICS_BIT_PIN1_OD]; // RULE_09
      pin1_spike_limit   <= pin_ctl_ff[`ICS_BIT_PIN1_SPIKE]; // RULE_10
    end
  end

  // ************************************************
  // apb read and answer
  // ************************************************
  assign rd_int_ctl = {30'h0, int_ctl_ff};
  assign rd_slew    = {24'h0, slew_ff, 4'h0}; // RULE_08
  assign rd_pin_ctl = {24'h0, pin_ctl_ff};
  assign rd_flag    = {{NSRC_PAD{1'b0}}, flag_ff};
  assign rd_mask    = {{NSRC_PAD{1'b0}}, mask_ff};
  assign rd_pol     = {{NSRC_PAD{1'b0}}, pol_ff};
  assign rd_live    = {{NSRC_PAD{1'b0}}, irq_live_state_ff}; // RULE_07
  assign rd_pin_sel = {31'h0, pin_sel_ff};

  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (widx)
      {2'h0, `ICS_IDX_INT_CTL}:   nxt_rdata = rd_int_ctl;
      {2'h0, `ICS_IDX_SLEW_STAT}: nxt_rdata = rd_slew; // RULE_08
      {2'h0, `ICS_IDX_PIN_CTL}:   nxt_rdata = rd_pin_ctl;
      {2'h0, `ICS_IDX_INT_FLAG}:  nxt_rdata = rd_flag;
      {2'h0, `ICS_IDX_INT_MASK}:  nxt_rdata = rd_mask;
      {2'h0, `ICS_IDX_INT_POL}:   nxt_rdata = rd_pol;
      {2'h0, `ICS_IDX_IRQ_LIVE_STATE}:  nxt_rdata = rd_live; // RULE_07
      {2'h0, `ICS_IDX_PIN_SEL}:   nxt_rdata = rd_pin_sel;
      default:                    nxt_rdata = 32'h0000_0000;
    endcase
  end

  assign hit = (widx >= {2'h0, `ICS_IDX_INT_CTL}) && (widx <= {2'h0, `ICS_IDX_PIN_SEL});

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= (nxt_state == ST_DONE);
      pslverr <= nxt_err;
      prdata  <= (acc & ~pwrite) ? nxt_rdata : 32'h0000_0000;
    end
  end

endmodule // ics_top
`default_nettype wire

// ### tb/ics_props.sv
// port assertions for the interrupt combine block
`default_nettype none
module ics_props (
  // apb and startup load
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic        cfg_load,
  input wire logic [1:0]  cfg_int_ctl,
  // status pins
  input wire logic        status_out_a, status_out_b, status_out_a_oe, pin0_open_drain_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_slew_ro: assert property (psel && penable && pwrite && !pready && paddr == 12'h048 |=> pslverr)
    else $error("slew write accepted");
  a_pin_excl: assert property (!(status_out_a && status_out_b))
    else $error("both pins active");
  a_off_quiet: assert property ((cfg_load && !cfg_int_ctl[0]) [*4] |-> !status_out_a && !status_out_b)
    else $error("pin active while disabled");
  a_oe_reset: assert property (!$past(presetn) |-> status_out_a_oe)
    else $error("pin not driven after reset");
  a_push_pull: assert property (!pin0_open_drain_en && !$past(pin0_open_drain_en) |-> status_out_a_oe)
    else $error("push-pull pin released");
endmodule // ics_props
`default_nettype wire

// ### tb/ics_host.sv
// host view of the two status pins, pulled up when released
`default_nettype none
module ics_host (
  input  wire logic a, a_oe, b, b_oe,
  output wire logic lvl_a, lvl_b
);
  timeunit 1ns;
  timeprecision 1ps;
  assign lvl_a = a_oe ? a : 1'b1;
  assign lvl_b = b_oe ? b : 1'b1;
endmodule // ics_host
`default_nettype wire

// ### tb/ics_top_tb.sv
// self-checking bench for the interrupt combine block
`default_nettype none
module ics_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, cfg_load = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, r;
  logic [3:0] pstrb = 4'hf, slew_valid = 0;
  logic [1:0] cfg_int_ctl = 0;
  logic [7:0] irq_src = 0;
  wire [31:0] prdata;
  wire pready, pslverr, status_out_a, status_out_a_oe, status_out_b, status_out_b_oe;
  wire pin0_open_drain_en, pin1_open_drain_en, pin0_spike_limit, pin1_spike_limit, lvl_a, lvl_b;
  int err_count = 0, check_count = 0;
  ics_top DUT (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .cfg_load, .cfg_int_ctl, .irq_src, .slew_valid,
    .status_out_a, .status_out_a_oe, .status_out_b, .status_out_b_oe, .pin0_open_drain_en,
    .pin1_open_drain_en, .pin0_spike_limit, .pin1_spike_limit);
  ics_host u_host (.a(status_out_a), .a_oe(status_out_a_oe), .b(status_out_b),
    .b_oe(status_out_b_oe), .lvl_a, .lvl_b);
  always #4 pclk = ~pclk;
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d); xf(1, a, d); endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x); xf(0, a, 0); chk(r, x); endtask
  task automatic w(input int n); repeat (n) @(posedge pclk); endtask
  task automatic t_reset();
    rd(12'h044, 0);
    rd(12'h048, 0);
    rd(12'h04c, 0);
    rd(12'h050, 0);
  endtask
  task automatic t_pin();
    wr(12'h04c, 32'hff);
    rd(12'h04c, 32'h3f);
    w(3);
    chk({pin1_spike_limit, pin0_spike_limit, pin1_open_drain_en, pin0_open_drain_en}, 4'hf);
    wr(12'h04c, 0);
  endtask
  task automatic t_slew();
    slew_valid <= 4'ha;
    rd(12'h048, 32'ha0);
    xf(1, 12'h048, 32'hff); chk(e, 1);
    rd(12'h048, 32'ha0);
    xf(0, 12'h070, 0); chk(e, 1);
  endtask
  task automatic t_off();
    wr(12'h058, 32'hff); irq_src <= 8'h01; w(5);
    rd(12'h050, 0);
    rd(12'h05c, 1);
    chk({lvl_b, lvl_a}, 0);
    irq_src <= 8'h00;
  endtask
  task automatic t_or();
    wr(12'h044, 1); irq_src <= 8'h02; w(5);
    rd(12'h050, 2);
    chk({lvl_b, lvl_a}, 1);
    wr(12'h054, 2); w(4); chk({lvl_b, lvl_a}, 0);
    wr(12'h054, 0); wr(12'h050, 0);
    rd(12'h050, 0);
  endtask
  task automatic t_freeze();
    clk_en <= 0;
    irq_src <= 8'h06;
    w(3);
    irq_src <= 8'h02;
    clk_en <= 1;
    w(2);
    rd(12'h050, 0);
    rd(12'h05c, 2);
  endtask
  task automatic t_and();
    wr(12'h058, 32'hfe); wr(12'h054, 32'hfc); wr(12'h044, 3);
    irq_src <= 8'h03; w(5); rd(12'h050, 0);
    irq_src <= 8'h02; w(5); rd(12'h050, 1);
    chk({lvl_b, lvl_a}, 0);
    irq_src <= 8'h00; w(3); irq_src <= 8'h02; w(5);
    chk({lvl_b, lvl_a}, 1);
    wr(12'h060, 1); w(4); chk({lvl_b, lvl_a}, 2);
    wr(12'h04c, 32'h02);
    w(3);
    chk(status_out_b_oe, 0);
    chk({lvl_b, lvl_a}, 2);
    wr(12'h04c, 0);
  endtask
  task automatic t_cfg();
    cfg_int_ctl <= 2'h0; cfg_load <= 1; w(6);
    chk({lvl_b, lvl_a}, 0);
    cfg_load <= 0; rd(12'h044, 0);
    cfg_int_ctl <= 2'h3; cfg_load <= 1; w(2); cfg_load <= 0;
    rd(12'h044, 3);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    t_reset(); t_pin(); t_slew(); t_off(); t_or(); t_freeze(); t_and(); t_cfg();
    summarize();
  end
  initial begin
    repeat (3000) @(posedge pclk);
    err_count++;
    summarize();
  end
endmodule // ics_top_tb
bind ics_top ics_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
  .paddr, .cfg_load, .cfg_int_ctl, .status_out_a, .status_out_b, .status_out_a_oe,
  .pin0_open_drain_en);
`default_nettype wire
